// >>> inc/oca_pkg.sv
// oca_pkg: constants shared by the character attribute decoder files
// assumes a single 40 MHz clock and a plain strobe register port
package oca_pkg;
  // ==========================================================
  // register port
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TEXT_PTR = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CHAR_BASE = 4'h3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] TEXT_PTR_RESET = 16'h0000;
  // control fields
  localparam int CTL_OSD_EN = 0;
  localparam int CTL_MODE_CSET = 1;
  localparam int CTL_PRIO = 2;
  localparam int CTL_WIDTH10 = 3;
  localparam int CTL_HEIGHT_LO = 4;
  localparam int CTL_GO = 6;
  localparam logic [1:0] HEIGHT_8 = 2'h0;
  localparam logic [1:0] HEIGHT_10 = 2'h1;
  localparam logic [1:0] HEIGHT_13 = 2'h2;
  localparam logic [3:0] UNDERLINE_SCAN = 4'hc;
  // ==========================================================
  // geometry
  localparam logic [3:0] PIX_W8 = 4'h8;
  localparam logic [3:0] PIX_W10 = 4'ha;
  localparam int CODE_W = 10;
  localparam int SCAN_W = 4;
  localparam int FONT_AW = CODE_W + SCAN_W;
  localparam int FONT_DW = 10;
  // ==========================================================
  // overlay text codes
  localparam logic [7:0] CODE_UL_ON = 8'h01;
  localparam logic [7:0] CODE_UL_OFF = 8'h02;
  localparam logic [7:0] CODE_FL_ON = 8'h03;
  localparam logic [7:0] CODE_FL_OFF = 8'h04;
  localparam logic [7:0] CODE_IT_ON = 8'h05;
  localparam logic [7:0] CODE_IT_OFF = 8'h06;
  localparam logic [7:0] CODE_TRANSP = 8'h07;
  localparam logic [7:0] CODE_SHADOW = 8'h08;
  localparam logic [7:0] CODE_END = 8'h0c;
  localparam logic [7:0] LINE_TERMINATE_CODE = 8'h0d;
  localparam logic [7:0] CODE_CHAR_MIN = 8'h0e;
  localparam logic [7:0] CODE_CTRL_MIN = 8'h80;
  localparam int CC_LATCH = 6;
  localparam int CC_WHITE_TRANSP = 6;
  localparam logic [2:0] RGB_WHITE = 3'h7;
  // ==========================================================
  // line buffer entry
  localparam int ENT_W = 22;
  typedef struct packed {
    logic underline;
    logic flash;
    logic italic;
    logic transp;
    logic shadow;
    logic white_transp;
    logic [2:0] fg;
    logic [2:0] bg;
    logic [CODE_W-1:0] code;
  } oca_entry_s;
  typedef enum logic [2:0] {OS_IDLE, OS_REQ, OS_DEC, OS_DONE} oca_osd_e;
  typedef enum logic [1:0] {FS_IDLE, FS_A, FS_B, FS_LOAD} oca_fetch_e;
endpackage : oca_pkg

// >>> inc/oca_buf_if.sv
// oca_buf_if: write and read port of the overlay line buffer
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface oca_buf_if #(parameter int AW = 6);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  oca_pkg::oca_entry_s wr_data;
  logic [AW-1:0] rd_addr;
  oca_pkg::oca_entry_s rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : oca_buf_if
`default_nettype wire

// >>> verilog/oca_line_buf.sv
// oca_line_buf: decoded overlay characters of one text line
// assumes one clock; read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module oca_line_buf #(
  parameter int AW = 6
) (
  input wire logic ref_clk,
  oca_buf_if.mem bus
);
  // ==========================================================
  // storage
  oca_pkg::oca_entry_s mem_r [0:(1<<AW)-1];
  oca_pkg::oca_entry_s rd_r;

  // write port and registered read port
  always_ff @(posedge ref_clk) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
    rd_r <= mem_r[bus.rd_addr];
  end

  assign bus.rd_data = rd_r;
endmodule : oca_line_buf
`default_nettype wire

// >>> verilog/oca_top.sv
// oca_top: four-colour character rendering and overlay text decoder
// assumes synchronous inputs, pix_en one cycle per pixel, one-cycle dma_ack
//
// Functional notes
// - colour-mode attribute set enables four-colour until cleared or row end.
// - four-colour mode is forced off at every row start.
// - four-colour character pixels carry two bits from two font planes.
// - even code n takes its second plane from entry n plus one.
// - odd code uses the same font entry for both planes.
// - 00 bg, 10 fg, 01 bg xor 8, 11 fg xor 8.
// - foreground flag comes from the first plane only.
// - overlay text and attributes are fetched by DMA reads.
// - overlay colours may take priority over teletext colours.
// - text read from pointer; 0Eh to 7Fh characters, 80h and up control.
// - after a control code one further read fetches the character.
// - 01/02 underline (13 lines only), 03/04 flash, 05/06 italics.
// - 07 makes layer transparent; 08 transparent with contrast reduced.
// - codes 0E to 7F are displayed as font characters.
// - overlay mode selects colour or character-set meaning of control codes.
// - colour code: bits 0-2 fg, 3-5 bg, bit 6 white transparent.
// - charset code: bits 0-2 give code bits 7-9, bit 6 latches.
// - cells 8 or 10 wide, 8, 10 or 13 tall, pixel rate enable.
`timescale 1ns/1ps
`default_nettype none
module oca_top #(
  parameter int BUF_AW = 6,
  parameter int DMA_AW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic pix_en,
  input wire logic row_start,
  input wire logic frame_start,
  input wire logic [3:0] scanline,
  input wire logic ttx_char_strobe,
  input wire logic [9:0] ttx_char_code,
  input wire logic [3:0] ttx_fg,
  input wire logic [3:0] ttx_bg,
  input wire logic ttx_cm_set,
  input wire logic ttx_cm_clr,
  output logic font_rd,
  output logic [13:0] font_addr,
  input wire logic [9:0] font_rdata,
  output logic dma_req,
  output logic [15:0] dma_addr,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  input wire logic [5:0] osd_rd_addr,
  input wire logic osd_font_bit,
  input wire logic flash_phase,
  output logic [3:0] pix_color,
  output logic pix_fg,
  output logic pix_osd,
  output logic pix_dim,
  output logic pix_italic
);
  // ==========================================================
  // helpers
  function automatic logic [3:0] four_col(input logic a, input logic b, input logic [3:0] fg,
                                          input logic [3:0] bg);
    logic [3:0] base;
    base = a ? fg : bg;
    four_col = b ? (base ^ 4'h8) : base;
  endfunction : four_col

  function automatic logic [3:0] cell_width(input logic w10);
    cell_width = w10 ? oca_pkg::PIX_W10 : oca_pkg::PIX_W8;
  endfunction : cell_width

  // ==========================================================
  // register port
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] tptr_r, tptr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic go_pulse;
  logic end_seen_r, end_seen_nxt;
  logic [5:0] line_cnt_r, line_cnt_nxt;
  logic [BUF_AW-1:0] col_r, col_nxt;
  oca_pkg::oca_osd_e os_r, os_nxt;
  logic cm_r, cm_nxt;
  logic [2:0] cs_latch_r, cs_latch_nxt;

  assign go_pulse = reg_wr && (reg_addr == oca_pkg::ADDR_CTRL) && reg_wdata[oca_pkg::CTL_GO];

  // register writes and read mux
  always_comb begin
    ctrl_nxt = ctrl_r;
    tptr_nxt = tptr_r;
    rdata_nxt = 16'h0000;
    if (reg_wr) begin
      unique case (reg_addr)
        oca_pkg::ADDR_CTRL: ctrl_nxt = reg_wdata & ~(16'h0001 << oca_pkg::CTL_GO);
        oca_pkg::ADDR_TEXT_PTR: tptr_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        oca_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
        oca_pkg::ADDR_TEXT_PTR: rdata_nxt = tptr_r;
        oca_pkg::ADDR_STATUS: rdata_nxt = {cm_r, end_seen_r, 2'(os_r), line_cnt_r, 6'(col_r)};
        oca_pkg::ADDR_CHAR_BASE: rdata_nxt = {13'h0000, cs_latch_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= oca_pkg::CTRL_RESET;
      tptr_r <= oca_pkg::TEXT_PTR_RESET;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      tptr_r <= tptr_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // ==========================================================
  // four-colour attribute and font fetch
  oca_pkg::oca_fetch_e fs_r, fs_nxt;
  logic [9:0] code_r, code_nxt;
  logic [3:0] fg_r, fg_nxt, bg_r, bg_nxt;
  logic char_cm_r, char_cm_nxt;
  logic [9:0] plane_a_r, plane_a_nxt, plane_b_r, plane_b_nxt;
  logic [9:0] shift_a_r, shift_a_nxt, shift_b_r, shift_b_nxt;
  logic [3:0] pix_cnt_r, pix_cnt_nxt;
  logic font_rd_r, font_rd_nxt;
  logic [13:0] font_addr_r, font_addr_nxt;

  // mode flag, fetch sequence and pixel shifters
  always_comb begin
    cm_nxt = cm_r;
    if (ttx_cm_set) cm_nxt = 1'b1;
    if (ttx_cm_clr) cm_nxt = 1'b0;
    if (row_start) cm_nxt = 1'b0;
    fs_nxt = fs_r;
    code_nxt = code_r;
    fg_nxt = fg_r;
    bg_nxt = bg_r;
    char_cm_nxt = char_cm_r;
    plane_a_nxt = plane_a_r;
    plane_b_nxt = plane_b_r;
    shift_a_nxt = shift_a_r;
    shift_b_nxt = shift_b_r;
    pix_cnt_nxt = pix_cnt_r;
    font_rd_nxt = 1'b0;
    font_addr_nxt = font_addr_r;
    if (pix_en && pix_cnt_r != 4'h0) begin
      shift_a_nxt = {shift_a_r[8:0], 1'b0};
      shift_b_nxt = {shift_b_r[8:0], 1'b0};
      pix_cnt_nxt = pix_cnt_r - 4'h1;
    end
    unique case (fs_r)
      oca_pkg::FS_IDLE: if (ttx_char_strobe) begin
        code_nxt = ttx_char_code;
        fg_nxt = ttx_fg;
        bg_nxt = ttx_bg;
        char_cm_nxt = (cm_r || ttx_cm_set) && !ttx_cm_clr && !row_start;
        font_rd_nxt = 1'b1;
        font_addr_nxt = {ttx_char_code, scanline};
        fs_nxt = oca_pkg::FS_A;
      end
      oca_pkg::FS_A: begin
        font_rd_nxt = 1'b1;
        font_addr_nxt = {code_r | 10'h001, scanline};
        fs_nxt = oca_pkg::FS_B;
      end
      oca_pkg::FS_B: begin
        plane_a_nxt = font_rdata;
        fs_nxt = oca_pkg::FS_LOAD;
      end
      oca_pkg::FS_LOAD: begin
        plane_b_nxt = font_rdata;
        shift_a_nxt = plane_a_r;
        shift_b_nxt = char_cm_r ? font_rdata : 10'h000;
        pix_cnt_nxt = cell_width(ctrl_r[oca_pkg::CTL_WIDTH10]);
        fs_nxt = oca_pkg::FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cm_r <= 1'b0;
      fs_r <= oca_pkg::FS_IDLE;
      code_r <= 10'h000;
      fg_r <= 4'h0;
      bg_r <= 4'h0;
      char_cm_r <= 1'b0;
      plane_a_r <= 10'h000;
      plane_b_r <= 10'h000;
      shift_a_r <= 10'h000;
      shift_b_r <= 10'h000;
      pix_cnt_r <= 4'h0;
      font_rd_r <= 1'b0;
      font_addr_r <= 14'h0000;
    end else begin
      cm_r <= cm_nxt;
      fs_r <= fs_nxt;
      code_r <= code_nxt;
      fg_r <= fg_nxt;
      bg_r <= bg_nxt;
      char_cm_r <= char_cm_nxt;
      plane_a_r <= plane_a_nxt;
      plane_b_r <= plane_b_nxt;
      shift_a_r <= shift_a_nxt;
      shift_b_r <= shift_b_nxt;
      pix_cnt_r <= pix_cnt_nxt;
      font_rd_r <= font_rd_nxt;
      font_addr_r <= font_addr_nxt;
    end
  end
  assign font_rd = font_rd_r;
  assign font_addr = font_addr_r;

  // ==========================================================
  // overlay text fetch and decode
  oca_buf_if #(.AW(BUF_AW)) buf_bus ();
  oca_pkg::oca_entry_s attr_r, attr_nxt;
  logic [2:0] cs_once_r, cs_once_nxt;
  logic cs_once_v_r, cs_once_v_nxt;
  logic [15:0] dptr_r, dptr_nxt;
  logic dma_req_r, dma_req_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic wr_en_r, wr_en_nxt;
  logic [BUF_AW-1:0] wr_addr_r, wr_addr_nxt;
  oca_pkg::oca_entry_s wr_data_r, wr_data_nxt;

  // dma request, byte decode and line buffer writes
  always_comb begin
    os_nxt = os_r;
    attr_nxt = attr_r;
    cs_latch_nxt = cs_latch_r;
    cs_once_nxt = cs_once_r;
    cs_once_v_nxt = cs_once_v_r;
    dptr_nxt = dptr_r;
    byte_nxt = byte_r;
    col_nxt = col_r;
    line_cnt_nxt = line_cnt_r;
    end_seen_nxt = end_seen_r;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    unique case (os_r)
      oca_pkg::OS_IDLE: ;
      oca_pkg::OS_REQ: if (dma_ack) begin
        byte_nxt = dma_rdata;
        dptr_nxt = dptr_r + 16'h0001;
        os_nxt = oca_pkg::OS_DEC;
      end
      oca_pkg::OS_DEC: begin
        os_nxt = oca_pkg::OS_REQ;
        if (byte_r >= oca_pkg::CODE_CTRL_MIN) begin
          if (ctrl_r[oca_pkg::CTL_MODE_CSET]) begin
            if (byte_r[oca_pkg::CC_LATCH]) cs_latch_nxt = byte_r[2:0];
            cs_once_nxt = byte_r[2:0];
            cs_once_v_nxt = 1'b1;
          end else begin
            attr_nxt.fg = byte_r[2:0];
            attr_nxt.bg = byte_r[5:3];
            attr_nxt.white_transp = byte_r[oca_pkg::CC_WHITE_TRANSP];
          end
        end else if (byte_r >= oca_pkg::CODE_CHAR_MIN) begin
          wr_en_nxt = 1'b1;
          wr_addr_nxt = col_r;
          wr_data_nxt = attr_r;
          wr_data_nxt.code = {cs_once_v_r ? cs_once_r : cs_latch_r, byte_r[6:0]};
          cs_once_v_nxt = 1'b0;
          if (col_r != {BUF_AW{1'b1}}) col_nxt = col_r + 1'b1;
        end else begin
          unique case (byte_r)
            oca_pkg::CODE_UL_ON: attr_nxt.underline = 1'b1;
            oca_pkg::CODE_UL_OFF: attr_nxt.underline = 1'b0;
            oca_pkg::CODE_FL_ON: attr_nxt.flash = 1'b1;
            oca_pkg::CODE_FL_OFF: attr_nxt.flash = 1'b0;
            oca_pkg::CODE_IT_ON: attr_nxt.italic = 1'b1;
            oca_pkg::CODE_IT_OFF: attr_nxt.italic = 1'b0;
            oca_pkg::CODE_TRANSP: attr_nxt.transp = 1'b1;
            oca_pkg::CODE_SHADOW: attr_nxt.shadow = 1'b1;
            oca_pkg::CODE_END: begin
              end_seen_nxt = 1'b1;
              os_nxt = oca_pkg::OS_DONE;
            end
            oca_pkg::LINE_TERMINATE_CODE: begin
              col_nxt = '0;
              line_cnt_nxt = line_cnt_r + 6'h01;
            end
            default: ;
          endcase
        end
      end
      oca_pkg::OS_DONE: ;
      default: os_nxt = oca_pkg::OS_IDLE;
    endcase
    if ((go_pulse || frame_start) && ctrl_r[oca_pkg::CTL_OSD_EN]) begin
      os_nxt = oca_pkg::OS_REQ;
      dptr_nxt = tptr_r;
      col_nxt = '0;
      line_cnt_nxt = 6'h00;
      end_seen_nxt = 1'b0;
      attr_nxt = '0;
      cs_once_v_nxt = 1'b0;
    end
    dma_req_nxt = (os_nxt == oca_pkg::OS_REQ);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      os_r <= oca_pkg::OS_IDLE;
      dma_req_r <= 1'b0;
      attr_r <= '0;
      cs_latch_r <= 3'h0;
      cs_once_r <= 3'h0;
      cs_once_v_r <= 1'b0;
      dptr_r <= 16'h0000;
      byte_r <= 8'h00;
      col_r <= '0;
      line_cnt_r <= 6'h00;
      end_seen_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      os_r <= os_nxt;
      dma_req_r <= dma_req_nxt;
      attr_r <= attr_nxt;
      cs_latch_r <= cs_latch_nxt;
      cs_once_r <= cs_once_nxt;
      cs_once_v_r <= cs_once_v_nxt;
      dptr_r <= dptr_nxt;
      byte_r <= byte_nxt;
      col_r <= col_nxt;
      line_cnt_r <= line_cnt_nxt;
      end_seen_r <= end_seen_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end
  assign dma_req = dma_req_r;
  assign dma_addr = dptr_r;

  assign buf_bus.wr_en = wr_en_r;
  assign buf_bus.wr_addr = wr_addr_r;
  assign buf_bus.wr_data = wr_data_r;
  assign buf_bus.rd_addr = osd_rd_addr[BUF_AW-1:0];

  oca_line_buf #(.AW(BUF_AW)) u_buf (
    .ref_clk(ref_clk),
    .bus(buf_bus.mem)
  );

  // ==========================================================
  // pixel colour and layer priority
  logic [3:0] color_r, color_nxt;
  logic fg_out_r, fg_out_nxt, osd_out_r, osd_out_nxt, dim_r, dim_nxt, ital_r, ital_nxt;
  oca_pkg::oca_entry_s oa;
  logic o_bit;
  logic [2:0] o_rgb;
  logic o_show;

  always_comb begin
    oa = buf_bus.rd_data;
    o_bit = osd_font_bit && !(oa.flash && flash_phase);
    if (oa.underline && ctrl_r[5:4] == oca_pkg::HEIGHT_13 && scanline == oca_pkg::UNDERLINE_SCAN) begin
      o_bit = 1'b1;
    end
    o_rgb = o_bit ? oa.fg : oa.bg;
    o_show = ctrl_r[oca_pkg::CTL_OSD_EN] && !oa.transp && !oa.shadow
             && !(oa.white_transp && o_rgb == oca_pkg::RGB_WHITE);
    color_nxt = color_r;
    fg_out_nxt = fg_out_r;
    osd_out_nxt = osd_out_r;
    dim_nxt = dim_r;
    ital_nxt = ital_r;
    if (pix_en) begin
      color_nxt = four_col(shift_a_r[9], shift_b_r[9], fg_r, bg_r);
      fg_out_nxt = shift_a_r[9];
      osd_out_nxt = 1'b0;
      dim_nxt = ctrl_r[oca_pkg::CTL_OSD_EN] && oa.shadow;
      ital_nxt = 1'b0;
      if (ctrl_r[oca_pkg::CTL_PRIO] && o_show) begin
        color_nxt = {1'b0, o_rgb};
        fg_out_nxt = o_bit;
        osd_out_nxt = 1'b1;
        ital_nxt = oa.italic;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      color_r <= 4'h0;
      fg_out_r <= 1'b0;
      osd_out_r <= 1'b0;
      dim_r <= 1'b0;
      ital_r <= 1'b0;
    end else begin
      color_r <= color_nxt;
      fg_out_r <= fg_out_nxt;
      osd_out_r <= osd_out_nxt;
      dim_r <= dim_nxt;
      ital_r <= ital_nxt;
    end
  end
  assign pix_color = color_r;
  assign pix_fg = fg_out_r;
  assign pix_osd = osd_out_r;
  assign pix_dim = dim_r;
  assign pix_italic = ital_r;
endmodule : oca_top
`default_nettype wire

// >>> dv/oca_top_sva.sv
// oca_top_sva: port level checks of the character attribute decoder
// assumes one ref_clk domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module oca_top_sva #(
  parameter int BUF_AW = 6,
  parameter int DMA_AW = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic row_start,
  input wire logic ttx_cm_set,
  input wire logic ttx_cm_clr,
  input wire logic font_rd,
  input wire logic [13:0] font_addr,
  input wire logic dma_req,
  input wire logic [15:0] dma_addr,
  input wire logic dma_ack,
  input wire logic pix_en,
  input wire logic [3:0] pix_color,
  input wire logic pix_fg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // sequences
  sequence s_status_rd;
    reg_rd && reg_addr == oca_pkg::ADDR_STATUS;
  endsequence
  sequence s_cm_set;
    ttx_cm_set && !ttx_cm_clr && !row_start ##1 !ttx_cm_clr && !row_start ##1 s_status_rd;
  endsequence
  sequence s_row_start;
    row_start ##1 !ttx_cm_set ##1 s_status_rd;
  endsequence
  sequence s_fetch;
    dma_ack ##1 !dma_req ##1 dma_req;
  endsequence
  // ==========================================================
  // assertions
  cm_set_a: assert property (s_cm_set |=> reg_rdata[15])
    else $error("four colour mode not seen after set");
  cm_row_a: assert property (s_row_start |=> !reg_rdata[15])
    else $error("four colour mode kept over row start");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  font_pair_a: assert property (font_rd && !$past(font_rd) |=>
    font_rd && font_addr == ($past(font_addr) | 14'h0010))
    else $error("second plane fetch not at code or one");
  font_two_a: assert property (font_rd && $past(font_rd) |=> !font_rd)
    else $error("more than two font fetches per character");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
    else $error("dma request dropped or moved before ack");
  dma_gap_a: assert property (dma_ack |=> !dma_req)
    else $error("no decode cycle after dma ack");
  dma_step_a: assert property (s_fetch |-> dma_addr == $past(dma_addr, 2) + 16'h0001)
    else $error("dma address not stepped by one");
  pix_hold_a: assert property (!$past(pix_en) |-> $stable(pix_color) && $stable(pix_fg))
    else $error("pixel output moved without pixel enable");
endmodule : oca_top_sva
bind oca_top oca_top_sva #(.BUF_AW(BUF_AW), .DMA_AW(DMA_AW)) u_sva (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .row_start(row_start),
  .ttx_cm_set(ttx_cm_set), .ttx_cm_clr(ttx_cm_clr), .font_rd(font_rd), .font_addr(font_addr),
  .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack), .pix_en(pix_en),
  .pix_color(pix_color), .pix_fg(pix_fg));
`default_nettype wire

// >>> dv/oca_dma_mem.sv
// oca_dma_mem: cpu memory behind the overlay dma port
// assumes one byte per ack and a request held until acked
`timescale 1ns/1ps
`default_nettype none
module oca_dma_mem (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] lat,
  input wire logic dma_req,
  input wire logic [15:0] dma_addr,
  output logic dma_ack,
  output logic [7:0] dma_rdata
);
  logic [7:0] mem [0:255];
  logic [15:0] addr_log [0:31];
  int ack_cnt;
  int wait_cnt;
  // ==========================================================
  // answer each request after lat idle cycles, one byte per ack
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dma_ack <= 1'b0;
      dma_rdata <= 8'h5a;
      wait_cnt <= 0;
      ack_cnt <= 0;
    end else if (dma_req && !dma_ack && wait_cnt >= int'(lat)) begin
      dma_ack <= 1'b1;
      dma_rdata <= mem[dma_addr[7:0]];
      addr_log[ack_cnt[4:0]] <= dma_addr;
      ack_cnt <= ack_cnt + 1;
      wait_cnt <= 0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata; // released data never holds
      wait_cnt <= (dma_req && !dma_ack) ? wait_cnt + 1 : 0;
    end
  end
endmodule : oca_dma_mem
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: register, four colour and overlay fetch tests of oca_top
// assumes oca_dma_mem as cpu memory and a behavioural font rom here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, reset, reg_wr, reg_rd, pix_en, row_start, frame_start, ttx_char_strobe;
  logic ttx_cm_set, ttx_cm_clr, font_rd, dma_req, dma_ack, osd_font_bit, flash_phase;
  logic pix_fg, pix_osd, pix_dim, pix_italic;
  logic [3:0] reg_addr, scanline, ttx_fg, ttx_bg, pix_color, lat;
  logic [15:0] reg_wdata, reg_rdata, dma_addr, rd;
  logic [9:0] ttx_char_code, font_rdata;
  logic [13:0] font_addr;
  logic [7:0] dma_rdata;
  logic [5:0] osd_rd_addr;
  logic [63:0] text0;
  logic [39:0] text1;
  int err_count, checks_done, i;
  oca_top #(.BUF_AW(6), .DMA_AW(16)) uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_en(pix_en),
    .row_start(row_start), .frame_start(frame_start), .scanline(scanline),
    .ttx_char_strobe(ttx_char_strobe), .ttx_char_code(ttx_char_code), .ttx_fg(ttx_fg),
    .ttx_bg(ttx_bg), .ttx_cm_set(ttx_cm_set), .ttx_cm_clr(ttx_cm_clr), .font_rd(font_rd),
    .font_addr(font_addr), .font_rdata(font_rdata), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_ack(dma_ack), .dma_rdata(dma_rdata), .osd_rd_addr(osd_rd_addr), .osd_font_bit(osd_font_bit),
    .flash_phase(flash_phase), .pix_color(pix_color), .pix_fg(pix_fg), .pix_osd(pix_osd),
    .pix_dim(pix_dim), .pix_italic(pix_italic));
  oca_dma_mem u_mem (.ref_clk(ref_clk), .reset(reset), .lat(lat), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  // 40 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // font rom: even codes 1100.., odd codes 1010.., data one cycle after font_rd
  always @(posedge ref_clk) font_rdata <= font_rd ? (font_addr[4] ? 10'h280 : 10'h300) : ~font_rdata;
  // ==========================================================
  // tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : reg_read
  // one cycle pulse on colour mode set, clear, row start and frame start
  task pulse(input logic s, input logic c, input logic r, input logic f);
    @(posedge ref_clk);
    {ttx_cm_set, ttx_cm_clr, row_start, frame_start} <= {s, c, r, f};
    @(posedge ref_clk);
    {ttx_cm_set, ttx_cm_clr, row_start, frame_start} <= 4'h0;
  endtask : pulse
  task pix_run(input logic [9:0] code, input logic [15:0] exp_c, input logic [3:0] exp_f);
    int k;
    @(posedge ref_clk);
    ttx_char_strobe <= 1'b1;
    ttx_char_code <= code;
    @(posedge ref_clk);
    ttx_char_strobe <= 1'b0;
    repeat (5) @(posedge ref_clk);
    pix_en <= 1'b1;
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      #1;
      chk({11'h0, pix_fg, pix_color}, {11'h0, exp_f[3-k], exp_c[15-4*k -: 4]});
    end
    repeat (8) @(posedge ref_clk);
    pix_en <= 1'b0;
  endtask : pix_run
  task wait_acks(input int n);
    int k;
    for (k = 0; k < 400 && u_mem.ack_cnt < n; k++) @(posedge ref_clk);
    if (u_mem.ack_cnt < n) begin
      err_count++;
      report_and_stop;
    end
  endtask : wait_acks
  // ==========================================================
  // main sequence
  initial begin
    {reg_wr, reg_rd, pix_en, row_start, frame_start, ttx_char_strobe, ttx_cm_set, ttx_cm_clr} = 8'h00;
    {osd_font_bit, flash_phase, reset} = 3'h1;
    {reg_addr, scanline, ttx_fg, ttx_bg, lat} = {4'h0, 4'h3, 4'h2, 4'h5, 4'h0};
    {reg_wdata, ttx_char_code, osd_rd_addr} = '0;
    err_count = 0;
    checks_done = 0;
    text0 = 64'h41_01_85_42_0d_43_07_0c; // one control code at most per char
    text1 = 40'hc5_41_83_42_0c;
    for (i = 0; i < 256; i++) u_mem.mem[i] = 8'h0c;
    for (i = 0; i < 8; i++) u_mem.mem[64+i] = text0[63-8*i -: 8];
    for (i = 0; i < 5; i++) u_mem.mem[96+i] = text1[39-8*i -: 8];
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // register reset values, unmapped place and read back
    reg_read(oca_pkg::ADDR_CTRL);
    chk(rd, oca_pkg::CTRL_RESET);
    reg_read(oca_pkg::ADDR_TEXT_PTR);
    chk(rd, oca_pkg::TEXT_PTR_RESET);
    reg_write(4'hf, 16'hffff);
    reg_read(4'hf);
    chk(rd, 16'h0000);
    reg_write(oca_pkg::ADDR_TEXT_PTR, 16'h0040);
    reg_write(oca_pkg::ADDR_CTRL, 16'h0004);
    reg_read(oca_pkg::ADDR_CTRL);
    chk(rd, 16'h0004);
    // four colour mode off, on, even and odd codes, row start and clear
    pix_run(10'h040, 16'h2255, 4'hc);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    reg_read(oca_pkg::ADDR_STATUS);
    chk({15'h0, rd[15]}, 16'h0001);
    pix_run(10'h040, 16'ha2d5, 4'hc);
    pix_run(10'h041, 16'ha5a5, 4'ha);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    reg_read(oca_pkg::ADDR_STATUS);
    chk({15'h0, rd[15]}, 16'h0000);
    pulse(1'b1, 1'b0, 1'b1, 1'b0);
    reg_read(oca_pkg::ADDR_STATUS);
    chk({15'h0, rd[15]}, 16'h0000);
    pix_run(10'h040, 16'h2255, 4'hc);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    reg_read(oca_pkg::ADDR_STATUS);
    chk({15'h0, rd[15]}, 16'h0000);
    // overlay fetch in colour mode with a prompt memory
    reg_write(oca_pkg::ADDR_CTRL, 16'h0005);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    wait_acks(8);
    repeat (20) @(posedge ref_clk);
    chk(16'(u_mem.ack_cnt), 16'h0008);
    for (i = 0; i < 8; i++) chk(u_mem.addr_log[i], 16'(64 + i));
    reg_read(oca_pkg::ADDR_STATUS);
    chk(rd, 16'h7041);
    @(posedge ref_clk);
    osd_rd_addr <= 6'h01;
    osd_font_bit <= 1'b1;
    pix_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({9'h0, pix_italic, pix_dim, pix_osd, pix_color}, 16'h0015);
    @(posedge ref_clk);
    pix_en <= 1'b0;
    // character set mode with a slow memory
    reg_write(oca_pkg::ADDR_CTRL, 16'h0003);
    reg_write(oca_pkg::ADDR_TEXT_PTR, 16'h0060);
    lat <= 4'h3;
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    wait_acks(13);
    repeat (20) @(posedge ref_clk);
    reg_read(oca_pkg::ADDR_CHAR_BASE);
    chk(rd, 16'h0005);
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
